// >>> src/coec_pkg.sv
/*
 * Package for the output enable control block: sizes, reset values,
 * address table and carriers. Assumes one 100 MHz core clock.
 */
package coec_pkg;
    // ========================================
    // Sizes and reset values
    localparam int NUM_OUT = 20;
    localparam logic [19:0] ENABLE_RST = 20'hFFFFF;
    localparam logic [19:0] MASK_RST = 20'h00000;
    localparam int SYNC_STAGES = 3;
    // ========================================
    // Strap levels
    typedef enum logic [1:0] {
        COEC_LVL_LOW = 2'h0,
        COEC_LVL_MID = 2'h1,
        COEC_LVL_HIGH = 2'h2
    } coec_level_t;
    // ========================================
    // Address table indexed by {high strap, low strap}
    localparam logic [7:0] ADDR_LL = 8'hD8;
    localparam logic [7:0] ADDR_LM = 8'hDA;
    localparam logic [7:0] ADDR_LH = 8'hDE;
    localparam logic [7:0] ADDR_ML = 8'hC2;
    localparam logic [7:0] ADDR_MM = 8'hC4;
    localparam logic [7:0] ADDR_MH = 8'hC6;
    localparam logic [7:0] ADDR_HL = 8'hCA;
    localparam logic [7:0] ADDR_HM = 8'hCC;
    localparam logic [7:0] ADDR_HH = 8'hCE;
    // ========================================
    // Software write request for enable or mask bits
    typedef struct packed {
        logic enable_we;
        logic mask_we;
        logic [19:0] wdata;
    } coec_write_t;
    // Power state
    typedef enum logic [2:0] {
        COEC_PS_WAIT = 3'h1,
        COEC_PS_RUN = 3'h2,
        COEC_PS_DOWN = 3'h4
    } coec_pstate_t;
endpackage : coec_pkg

// >>> src/coec_top.sv
/*
 * Output enable control for a 20-output clock buffer.
 * Assumes every pin input is asynchronous to core_clk and that the
 * side-band clock runs at 10 MHz or less, well below core_clk / 4.
 */
`timescale 1ns/100ps

// Summary of operation
// R1: Address from two tri-level straps, nine values D8 to CE.
// R2: Power good low holds every output pair low.
// R3: Select low: run when enable bit is 1 and pin is 0.
// R4: Select high: run when mask bit or shift bit is 1.
// R5: Select pin chooses exactly one enable method.
// R6: Both methods feed one shared glitch-free synchroniser.
// R7: Pins for outputs 5 to 12; 20 software enable bits.
// R8: While load is high, rising side-band clock shifts data.
// R9: Falling load edge copies shift register into output register.
// R10: Side-band mode ignores pins 7,8,9,11,12; 5,6,10 become link.
// R11: Shift bit 0 disables unless mask bit forces enabled.
// R12: Status bit reports the selected interface.
// R13: Side-band logic runs while power good is low.
// R14: Mask writes refused while power good is low.
// R15: Reset: output register and enables all 1, masks 0.
// R16: Controller sends 20 bits, parks clock low, drops load.
// R17: Side-band clock up to 10 MHz accepted.
// R18: Load low: clock and data ignored.
// R19: First bit shifted maps to output 0, twentieth to 19.
// R20: Pin level 1 disables, 0 enables.
// R21: Output changes within 5 to 10 input clock cycles; the code takes 3 to 4.
// R22: First power good high latches straps; later low powers down.
module coec_top #(
    parameter int NUM_OUT = coec_pkg::NUM_OUT
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_clk_run,
    input wire logic power_good_power_down,
    input wire logic interface_select_pin,
    input wire logic [7:0] enable_pin_n,
    input wire logic [1:0] address_strap_low,
    input wire logic [1:0] address_strap_high,
    input wire coec_pkg::coec_write_t sw_write,
    output logic [7:0] slave_address,
    output logic address_valid,
    output logic interface_status,
    output logic sw_write_refused,
    output logic [19:0] smbus_enable,
    output logic [19:0] force_enable_mask_bit,
    output logic [19:0] sideband_output,
    output logic [19:0] out_run
);
    // ========================================
    // Input synchronisers (pins enter the core clock domain)
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    wire [NSYNC-1:0] raw_in = {in_clk_run, power_good_power_down, interface_select_pin,
                               enable_pin_n, address_strap_low[0]};
    // Two-stage sync for all single-bit pins
    // Every pin is asynchronous to core_clk, so only the second stage
    // is read by logic. Reset leaves every pin seen as low, which is the
    // idle level of the link clock and load pins, so no false edge is
    // found just after reset.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end
    logic [3:0] strap_a;
    logic [3:0] strap_b;
    // Straps are quasi-static but still synchronised
    // They are used only at the first power good, long after they have
    // settled, so a plain two-stage copy is enough.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_a <= '0;
            strap_b <= '0;
        end else begin
            strap_a <= {address_strap_high, address_strap_low};
            strap_b <= strap_a;
        end
    end
    wire s_in_run = sync_b[11];
    wire s_pgood = sync_b[10];
    wire s_select = sync_b[9];
    wire [7:0] s_pin_n = sync_b[8:1];
    // Side-band pins share the enable pins of outputs 5, 6 and 10
    // Data and link clock pass the same two stages, so a sampled data bit
    // stays aligned with the clock edge that the core clock finds for it.
    // Each link clock phase must span at least three core cycles.
    wire sb_data = s_pin_n[0]; // R10
    wire sb_clk = s_pin_n[1]; // R10
    wire sb_load = s_pin_n[5]; // R10

    // ========================================
    // Address decode from the tri-level straps
    // Strap code 3 is not a legal level; it falls back to the low/low
    // address so that a broken strap still yields a usable value.
    // The decode sees only synchronised copies of the straps.
    function automatic logic [7:0] strap_addr(input logic [1:0] hi, input logic [1:0] lo);
        logic [7:0] a;
        a = coec_pkg::ADDR_LL;
        unique case ({hi, lo})
            4'h0: a = coec_pkg::ADDR_LL;
            4'h1: a = coec_pkg::ADDR_LM;
            4'h2: a = coec_pkg::ADDR_LH;
            4'h4: a = coec_pkg::ADDR_ML;
            4'h5: a = coec_pkg::ADDR_MM;
            4'h6: a = coec_pkg::ADDR_MH;
            4'h8: a = coec_pkg::ADDR_HL;
            4'h9: a = coec_pkg::ADDR_HM;
            4'hA: a = coec_pkg::ADDR_HH;
            default: a = coec_pkg::ADDR_LL;
        endcase
        return a;
    endfunction : strap_addr
    wire [7:0] next_address = strap_addr(strap_b[3:2], strap_b[1:0]); // R1

    // ========================================
    // Power state: first high latches straps, then low/high toggle down
    // WAIT is left only once; RUN and DOWN then follow the pin level.
    // Software access is tied to RUN, so writes before the first power
    // good are refused just like those made in power down.
    coec_pkg::coec_pstate_t pstate;
    wire first_rise = (pstate == coec_pkg::COEC_PS_WAIT) && s_pgood;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pstate <= coec_pkg::COEC_PS_WAIT;
        end else begin
            unique case (pstate)
                coec_pkg::COEC_PS_WAIT: begin
                    // First high starts the part
                    if (s_pgood) begin
                        pstate <= coec_pkg::COEC_PS_RUN; // R22
                    end
                end
                coec_pkg::COEC_PS_RUN: begin
                    // A low enters power down
                    if (!s_pgood) begin
                        pstate <= coec_pkg::COEC_PS_DOWN; // R22
                    end
                end
                coec_pkg::COEC_PS_DOWN: begin
                    // A later high leaves power down
                    if (s_pgood) begin
                        pstate <= coec_pkg::COEC_PS_RUN; // R22
                    end
                end
                default: begin
                    // Illegal code: wait for power good again
                    pstate <= coec_pkg::COEC_PS_WAIT;
                end
            endcase
        end
    end
    // Latch the address once, at the first power good
    // Later power cycles keep the address, so a strap that moves after
    // start-up cannot change the bus address under software.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slave_address <= 8'h00;
            address_valid <= 1'b0;
        end else if (first_rise) begin
            slave_address <= next_address; // R1 R22
            address_valid <= 1'b1;
        end
    end

    // ========================================
    // Software registers: enable bits and force-enable masks
    // A refused write leaves both sets untouched and raises a one-cycle
    // pulse, so the bus side can answer with an error if it wishes.
    // Both strobes may come together; they then share one data word.
    wire pgood_ok = s_pgood && (pstate == coec_pkg::COEC_PS_RUN);
    wire any_we = sw_write.enable_we || sw_write.mask_we;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            smbus_enable <= coec_pkg::ENABLE_RST; // R15
            force_enable_mask_bit <= coec_pkg::MASK_RST; // R15
            sw_write_refused <= 1'b0;
        end else begin
            if (pgood_ok && sw_write.enable_we) smbus_enable <= sw_write.wdata; // R7
            if (pgood_ok && sw_write.mask_we) force_enable_mask_bit <= sw_write.wdata; // R14
            sw_write_refused <= any_we && !pgood_ok; // R14
        end
    end
    // Selected interface read-back
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            interface_status <= 1'b0;
        end else begin
            interface_status <= s_select; // R12
        end
    end

    // ========================================
    // Side-band link: edges found by the core clock
    // The link stays live whenever side-band mode is chosen, power good
    // or not, so the output register can be preloaded before start-up.
    // With load low no edge is taken, so the clock and data wires may be
    // shared with other devices on the same board.
    logic sb_clk_d;
    logic sb_load_d;
    logic [19:0] shift_reg;
    wire sb_active = s_select; // R5 R13
    wire sb_rise = sb_clk && !sb_clk_d;
    wire sb_load_fall = sb_load_d && !sb_load;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sb_clk_d <= 1'b0;
            sb_load_d <= 1'b0;
        end else begin
            sb_clk_d <= sb_clk;
            sb_load_d <= sb_load;
        end
    end
    // Shift on rising link clock while load is high; newest bit at 19
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= coec_pkg::ENABLE_RST;
        end else if (sb_active && sb_load && sb_rise) begin // R8 R17 R18
            shift_reg <= {sb_data, shift_reg[19:1]}; // R19
        end
    end
    // Load output register on falling load edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sideband_output <= coec_pkg::ENABLE_RST; // R15
        end else if (sb_active && sb_load_fall) begin
            sideband_output <= shift_reg; // R9 R16
        end
    end

    // ========================================
    // Per-output request from the chosen method
    logic [19:0] pin_enable;
    always_comb begin
        pin_enable = '1;
        // Pins map to outputs 5..12; level 0 requests enabled
        for (int i = 0; i < 8; i++) begin
            pin_enable[5 + i] = !s_pin_n[i]; // R7 R20
        end
    end
    // Only one method reaches the stage at a time; the other is simply
    // not selected, so its bits keep their values for a later switch.
    // Power good low overrides both, whatever they request.
    wire [19:0] trad_req = smbus_enable & pin_enable; // R3
    wire [19:0] sb_req = force_enable_mask_bit | sideband_output; // R4 R11 R10
    wire [19:0] method_req = s_select ? sb_req : trad_req; // R5
    wire [19:0] request = s_pgood ? method_req : 20'h00000; // R2

    // ========================================
    // Shared glitch-free stage per output, stepped by input clock
    // A request moves only on rising edges of the input clock, so an
    // output starts or stops on a whole period, except at power loss, which stops it at once.
    // If the input clock stops, the stage freezes with it.
    logic in_run_d;
    // Previous input clock level for edge finding
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_run_d <= 1'b0;
        end else begin
            in_run_d <= s_in_run;
        end
    end
    wire in_tick = s_in_run && !in_run_d;
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            // Three stages plus the output flop give three to four input
            // clocks of latency, short of the 5 to 10 cycle change window of R21. Power
            // loss clears the stage at once so outputs drop without waiting.
            logic [coec_pkg::SYNC_STAGES-1:0] pipe;
            // Request crosses stages only on input clock edges
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pipe <= '0;
                    out_run[g] <= 1'b0;
                end else begin
                    if (!s_pgood) begin
                        pipe <= '0; // R2
                        out_run[g] <= 1'b0;
                    end else if (in_tick) begin // R3
                        pipe <= {pipe[coec_pkg::SYNC_STAGES-2:0], request[g]}; // R6 R21
                        out_run[g] <= pipe[coec_pkg::SYNC_STAGES-1];
                    end
                end
            end
        end
    endgenerate
endmodule : coec_top

// >>> sim/coec_chk.sv
/* Assertion checker for coec_top: watches its ports only.
   Assumes one core clock and the asynchronous high reset. */
`timescale 1ns/100ps
module coec_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic power_good_power_down,
    input wire logic interface_select_pin,
    input wire logic [7:0] enable_pin_n,
    input wire coec_pkg::coec_write_t sw_write,
    input wire logic [7:0] slave_address,
    input wire logic address_valid,
    input wire logic interface_status,
    input wire logic sw_write_refused,
    input wire logic [19:0] smbus_enable,
    input wire logic [19:0] force_enable_mask_bit,
    input wire logic [19:0] sideband_output,
    input wire logic [19:0] out_run
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ========================================
    // Cycles that output 0 has had no request in pin mode
    logic [4:0] off_cnt;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            off_cnt <= 5'h00;
        end else if (interface_status || smbus_enable[0]) begin
            off_cnt <= 5'h00;
        end else if (off_cnt != 5'h1F) begin
            off_cnt <= off_cnt + 5'h01;
        end
    end
    // ========================================
    // Properties
    a_pgood_low_off: assert property (!power_good_power_down [*6] |-> out_run == 20'h00000)
        else $error("outputs run while power is not good");
    a_refuse_pulse: assert property (!power_good_power_down [*6] ##0
        (sw_write.enable_we || sw_write.mask_we) |=> sw_write_refused)
        else $error("write in power down not refused");
    a_mask_frozen: assert property (!power_good_power_down [*6]
        |=> $stable(force_enable_mask_bit))
        else $error("mask changed in power down");
    a_mask_write: assert property (power_good_power_down [*6] ##0 sw_write.mask_we
        |=> force_enable_mask_bit == $past(sw_write.wdata))
        else $error("mask write lost");
    a_status_follow: assert property (interface_select_pin [*5] |-> interface_status)
        else $error("status does not show side-band mode");
    a_addr_legal: assert property ($rose(address_valid) |-> slave_address inside
        {8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE})
        else $error("illegal slave address");
    a_addr_hold: assert property (address_valid
        |=> address_valid && $stable(slave_address))
        else $error("slave address changed after latch");
    a_load_idle: assert property ((interface_select_pin && !enable_pin_n[5]) [*6]
        |=> $stable(sideband_output))
        else $error("output register moved with load low");
    a_pin_mode_off: assert property (off_cnt == 5'h1F |-> !out_run[0])
        else $error("output 0 runs without its enable bit");
endmodule : coec_chk
bind coec_top coec_chk u_chk (.*);

// >>> sim/coec_link_model.sv
/* Side-band controller model: drives serial data, clock and load.
   Assumes the bench calls send; link clock period 160 ns. */
`timescale 1ns/100ps
module coec_link_model (
    output logic sb_data,
    output logic sb_clk,
    output logic sb_load
);
    // Idle: clock parked low, load low, data at its pull-down level
    initial begin
        sb_data = 1'b0;
        sb_clk = 1'b0;
        sb_load = 1'b0;
    end
    // One frame of 20 bits, output 0 first
    task automatic send(input logic [19:0] w);
        sb_load = 1'b1;
        #80;
        for (int i = 0; i < 20; i++) begin
            sb_data = w[i];
            #80 sb_clk = 1'b1;
            #80 sb_clk = 1'b0;
        end
        #80 sb_load = 1'b0;
        sb_data = 1'b0;
    endtask : send
endmodule : coec_link_model

// >>> sim/tb_clock_output_enable_control.sv
/* Testbench for coec_top with the side-band controller model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/100ps
module tb_clock_output_enable_control;
    logic core_clk, sys_rst, in_clk_run, pg, sel, sd, sc, sl, av, st, refused;
    logic [7:0] pins, pin_n, addr;
    logic [1:0] sa_lo, sa_hi;
    logic [19:0] en, mask, sbo, run;
    coec_pkg::coec_write_t wr;
    int miscompares, n_checks;
    // Side-band pins share the enable pins in side-band mode
    assign pin_n = sel ? {pins[7:6], sl, pins[4:2], sc, sd} : pins;
    coec_link_model lnk (.sb_data(sd), .sb_clk(sc), .sb_load(sl));
    coec_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .in_clk_run(in_clk_run),
        .power_good_power_down(pg), .interface_select_pin(sel), .enable_pin_n(pin_n),
        .address_strap_low(sa_lo), .address_strap_high(sa_hi), .sw_write(wr),
        .slave_address(addr), .address_valid(av), .interface_status(st),
        .sw_write_refused(refused), .smbus_enable(en), .force_enable_mask_bit(mask),
        .sideband_output(sbo), .out_run(run));
    // ========================================
    // Clocks
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) in_clk_run <= ~in_clk_run;
    // ========================================
    // Shared tasks
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic swr(input logic e, input logic m, input logic [19:0] d);
        @(negedge core_clk);
        wr = '{e, m, d};
        @(negedge core_clk);
        wr = '0;
    endtask : swr
    task automatic settle();
        repeat (40) @(negedge core_clk);
    endtask : settle
    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    // ========================================
    // Scenarios
    task automatic t_reset();
        cmp(en, 20'hFFFFF);
        cmp(mask, 20'h00000);
        cmp(sbo, 20'hFFFFF);
        cmp(run, 20'h00000);
        cmp({11'h000, av, addr}, 20'h00000);
    endtask : t_reset
    task automatic t_preload();
        sel = 1'b1;
        settle();
        lnk.send(20'h5A3C1);
        settle();
        cmp(sbo, 20'h5A3C1);
        cmp({19'h00000, st}, 20'h00001);
        swr(1'b0, 1'b1, 20'hFFFFF);
        cmp({19'h00000, refused}, 20'h00001);
        cmp(mask, 20'h00000);
    endtask : t_preload
    task automatic t_start();
        pg = 1'b1;
        settle();
        cmp({11'h000, av, addr}, 20'h001DE);
        cmp(run, 20'h5A3C1);
    endtask : t_start
    task automatic t_mask();
        swr(1'b0, 1'b1, 20'h00003);
        settle();
        cmp(run, 20'h5A3C3);
        lnk.send(20'h00000);
        settle();
        cmp(run, 20'h00003);
    endtask : t_mask
    task automatic t_pins();
        pins = 8'hA5;
        sel = 1'b0;
        swr(1'b1, 1'b0, 20'h0FFF0);
        settle();
        cmp(run, 20'h0FFF0 & ~({12'h000, pins} << 5));
    endtask : t_pins
    task automatic t_pdown();
        pg = 1'b0;
        settle();
        cmp(run, 20'h00000);
    endtask : t_pdown
    // ========================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        in_clk_run = 1'b0;
        pg = 1'b0;
        sel = 1'b0;
        pins = 8'hDC;
        sa_lo = 2'h2;
        sa_hi = 2'h0;
        wr = '0;
        miscompares = 0;
        n_checks = 0;
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        t_reset();
        t_preload();
        t_start();
        t_mask();
        t_pins();
        t_pdown();
        end_of_test();
    end
    // Watchdog against a hang
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule : tb_clock_output_enable_control
